/* File: hdl/pcc_pkg.sv */
/*
  Constants, register layout and carrier types for the PLL and core clock control block.
  Assumes a single clock domain; the register sits on an AHB-Lite slave with 32-bit data.
*/
package pcc_pkg;

  // Byte offset of the clock control register
  localparam logic [11:0] PCC_CTRL_OFFSET = 12'h000;

  // Bit positions inside the clock control byte
  localparam int PCC_OSC_HALT_BIT = 7;
  localparam int PCC_LOCK_BIT     = 6;
  localparam int PCC_RSVD_BIT     = 5;
  localparam int PCC_LATCHED_EXT_ACCESS_PIN_BIT     = 4;
  localparam int PCC_FAST_IRQ_FULL_SPEED_BIT     = 3;
  localparam int PCC_DIV_LSB      = 0;
  localparam int PCC_DIV_W        = 3;
  localparam int PCC_CNT_W        = 7;

  // Power-on value: divide by eight, override off, oscillator kept in sleep
  localparam logic [7:0] PCC_CTRL_RESET = 8'h03;

  // Fixed PLL multiplication of the crystal reference
  localparam logic [15:0] PCC_PLL_MULT = 16'h0180;

  // AHB-Lite transfer type bit that marks NONSEQ or SEQ
  localparam int PCC_HTRANS_ACTIVE_BIT = 1;

  typedef struct packed {
    logic                 osc_halt_in_sleep;
    logic                 fast_irq_full_speed;
    logic [PCC_DIV_W-1:0] core_div;
  } pcc_ctrl_t;

endpackage : pcc_pkg

/* File: hdl/pcc_clk_div.sv */
/*
  Core clock enable generator: one tick every 2**active_div cycles of the PLL clock.
  Assumes div_sel and full_speed come from logic on the same clock.
*/
`timescale 1ns/100ps
module pcc_clk_div
  import pcc_pkg::*;
#(
  parameter int DIV_W = PCC_DIV_W,
  parameter int CNT_W = PCC_CNT_W
)(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [DIV_W-1:0] div_sel,
  input  wire logic             full_speed,
  output logic                  tick,
  output logic [DIV_W-1:0]      active_div
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] term_mask;
  logic             terminal;

  always_comb
  begin
    term_mask = CNT_W'((1 << active_div) - 1);
    terminal  = (cnt == term_mask);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt <= '0;
    else if (clk_en)
      cnt <= terminal ? '0 : CNT_W'(cnt + 1'b1);
  end

  // Rate only changes at a period boundary, so no short core period appears
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      active_div <= PCC_CTRL_RESET[PCC_DIV_W-1:0];
    else if (clk_en && terminal)
      active_div <= full_speed ? '0 : div_sel;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tick <= 1'b0;
    else if (clk_en)
      tick <= terminal;
  end

  property p_no_runt;
    @(posedge clk) disable iff (!rst_n)
    !$stable(active_div) |-> $past(terminal) && $past(clk_en);
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("Divider changed mid-period");

  property p_full_speed;
    @(posedge clk) disable iff (!rst_n)
    full_speed && terminal && clk_en |=> active_div == '0;
  endproperty
  a_full_speed: assert property (p_full_speed) else $error("Override did not select full rate");

  property p_div_load;
    @(posedge clk) disable iff (!rst_n)
    !full_speed && terminal && clk_en |=> active_div == $past(div_sel);
  endproperty
  a_div_load: assert property (p_div_load) else $error("Divider code not taken");

  property p_half_rate;
    @(posedge clk) disable iff (!rst_n)
    active_div == 3'h1 && clk_en && tick ##1 clk_en |-> !tick;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("Divide by two ticks too often");

  c_full: cover property (@(posedge clk) active_div == 3'h0 && tick ##1 tick);
  c_slow: cover property (@(posedge clk) active_div == 3'h7 && tick);

endmodule : pcc_clk_div

/* File: hdl/pcc_top.sv */
/*
  PLL and core clock control: one control/status register on AHB-Lite, the core clock
  enable divider, lock reporting, external-access strap capture and oscillator sleep control.
  Assumes PLL_TRACKING and EXT_ACCESS_PIN are asynchronous; power-down and interrupt
  entry/return signals come from core logic on CORE_CLK.
*/
`timescale 1ns/100ps
//  Summary of operation
// - Control bit 7 set stops the crystal oscillator in power-down; clear keeps it.
// - Bit 6 is a read-only lock flag set while the PLL tracks the crystal.
// - Lock flag clears whenever the PLL is not tracking the crystal.
// - Bit 4 returns the external-access pin captured at the last reset.
// - Bit 3 set runs interrupt handling at full undivided core rate.
// - On interrupt return the core goes back to the divider-selected rate.
// - Bits 2 to 0 divide the PLL clock by two to the field value.
// - Default core clock is PLL clock divided by eight, code 011.
// - The PLL multiplies the crystal reference by a fixed factor of 384.
module pcc_top
  import pcc_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        CLK_EN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        PLL_TRACKING,
  input  wire logic        EXT_ACCESS_PIN,
  input  wire logic        POWER_DOWN,
  input  wire logic        IRQ_ENTRY,
  input  wire logic        IRQ_RETURN,
  output logic             CORE_CLK_EN,
  output logic             OSC_RUN,
  output logic      [15:0] PLL_MULT_FACTOR
);

  pcc_ctrl_t             ctrl;
  logic                  trk_s1;
  logic                  trk_s2;
  logic                  ea_s1;
  logic                  ea_s2;
  logic                  lock;
  logic                  latched_ext_access_pin;
  logic                  in_service;
  logic                  full_speed;
  logic                  addr_valid;
  logic                  addr_hit;
  logic                  wr_pend;
  logic [7:0]            status_byte;
  logic [PCC_DIV_W-1:0]  active_div;

  // Asynchronous inputs: two flops before any logic
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      trk_s1 <= 1'b0;
      trk_s2 <= 1'b0;
    end
    else if (CLK_EN)
    begin
      trk_s1 <= PLL_TRACKING;
      trk_s2 <= trk_s1;
    end
  end

  // Not reset, so the strap level is already settled when the capture below reads it
  always_ff @(posedge CORE_CLK)
  begin
    if (CLK_EN)
    begin
      ea_s1 <= EXT_ACCESS_PIN;
      ea_s2 <= ea_s1;
    end
  end

  // Lock follows the tracking detector; no write path reaches it
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      lock <= 1'b0;
    else if (CLK_EN)
      lock <= trk_s2;
  end

  // Strap sampled during reset and frozen once reset is released
  always_ff @(posedge CORE_CLK)
  begin
    if (CLK_EN && !RST_N)
      latched_ext_access_pin <= ea_s2;
  end

  // AHB-Lite address phase decode; one register, others read zero
  always_comb
  begin
    addr_valid  = HSEL && HTRANS[PCC_HTRANS_ACTIVE_BIT] && HREADY;
    addr_hit    = (HADDR[11:0] == PCC_CTRL_OFFSET);
    status_byte = '0;
    status_byte[PCC_OSC_HALT_BIT] = ctrl.osc_halt_in_sleep;
    status_byte[PCC_LOCK_BIT]     = lock;
    status_byte[PCC_LATCHED_EXT_ACCESS_PIN_BIT]     = latched_ext_access_pin;
    status_byte[PCC_FAST_IRQ_FULL_SPEED_BIT]     = ctrl.fast_irq_full_speed;
    status_byte[PCC_DIV_LSB +: PCC_DIV_W] = ctrl.core_div;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      wr_pend <= 1'b0;
    else if (CLK_EN)
      wr_pend <= addr_valid && HWRITE && addr_hit;
  end

  // Read data is ready at the start of the data phase, so no wait states
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      HRDATA <= '0;
    else if (CLK_EN && addr_valid)
      HRDATA <= (!HWRITE && addr_hit) ? {24'h000000, status_byte} : 32'h00000000;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
    else if (CLK_EN)
    begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // Lock, strap and reserved bits are dropped from the write data
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      ctrl.osc_halt_in_sleep   <= PCC_CTRL_RESET[PCC_OSC_HALT_BIT];
      ctrl.fast_irq_full_speed <= PCC_CTRL_RESET[PCC_FAST_IRQ_FULL_SPEED_BIT];
      ctrl.core_div            <= PCC_CTRL_RESET[PCC_DIV_LSB +: PCC_DIV_W];
    end
    else if (CLK_EN && wr_pend)
    begin
      ctrl.osc_halt_in_sleep   <= HWDATA[PCC_OSC_HALT_BIT];
      ctrl.fast_irq_full_speed <= HWDATA[PCC_FAST_IRQ_FULL_SPEED_BIT];
      ctrl.core_div            <= HWDATA[PCC_DIV_LSB +: PCC_DIV_W];
    end
  end

  // Interrupt in service; return wins over a simultaneous entry
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      in_service <= 1'b0;
    else if (CLK_EN)
    begin
      if (IRQ_RETURN)
        in_service <= 1'b0;
      else if (IRQ_ENTRY)
        in_service <= 1'b1;
    end
  end

  assign full_speed = ctrl.fast_irq_full_speed && in_service;

  // Oscillator halts only when sleeping and told to
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      OSC_RUN <= 1'b1;
    else if (CLK_EN)
      OSC_RUN <= !(POWER_DOWN && ctrl.osc_halt_in_sleep);
  end

  // The analog loop uses this constant as its feedback divide
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      PLL_MULT_FACTOR <= PCC_PLL_MULT;
    else if (CLK_EN)
      PLL_MULT_FACTOR <= PCC_PLL_MULT;
  end

  // Enable pulses rather than a gated clock keep every core period whole
  pcc_clk_div #(
    .DIV_W (PCC_DIV_W),
    .CNT_W (PCC_CNT_W)
  ) u_div (
    .clk        (CORE_CLK),
    .rst_n      (RST_N),
    .clk_en     (CLK_EN),
    .div_sel    (ctrl.core_div),
    .full_speed (full_speed),
    .tick       (CORE_CLK_EN),
    .active_div (active_div)
  );

  property p_osc;
    @(posedge CORE_CLK) disable iff (!RST_N)
    CLK_EN |=> OSC_RUN == !($past(POWER_DOWN) && $past(ctrl.osc_halt_in_sleep));
  endproperty
  a_osc: assert property (p_osc) else $error("Oscillator sleep control wrong");

  property p_lock_ro;
    @(posedge CORE_CLK) disable iff (!RST_N)
    !$stable(lock) |-> lock == $past(trk_s2);
  endproperty
  a_lock_ro: assert property (p_lock_ro) else $error("Lock flag moved without detector");

  property p_lock_clear;
    @(posedge CORE_CLK) disable iff (!RST_N)
    !trk_s2 && CLK_EN |=> !lock;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("Lock set while not tracking");

  property p_latched_ext_access_pin_hold;
    @(posedge CORE_CLK) disable iff (!RST_N)
    $past(RST_N) |-> $stable(latched_ext_access_pin);
  endproperty
  a_latched_ext_access_pin_hold: assert property (p_latched_ext_access_pin_hold) else $error("Strap capture changed");

  property p_irq_return;
    @(posedge CORE_CLK) disable iff (!RST_N)
    IRQ_RETURN && CLK_EN |=> !full_speed;
  endproperty
  a_irq_return: assert property (p_irq_return) else $error("Override kept after return");

  property p_fast_irq_full_speed_off;
    @(posedge CORE_CLK) disable iff (!RST_N)
    !ctrl.fast_irq_full_speed |-> !full_speed;
  endproperty
  a_fast_irq_full_speed_off: assert property (p_fast_irq_full_speed_off) else $error("Override active while disabled");

  property p_reset_div;
    @(posedge CORE_CLK)
    !RST_N |=> ctrl.core_div == 3'h3 && active_div == 3'h3;
  endproperty
  a_reset_div: assert property (p_reset_div) else $error("Reset divider not divide by eight");

  property p_mult;
    @(posedge CORE_CLK) disable iff (!RST_N)
    $past(RST_N) |-> PLL_MULT_FACTOR == 16'h0180;
  endproperty
  a_mult: assert property (p_mult) else $error("PLL factor not 384");

  c_write: cover property (@(posedge CORE_CLK) wr_pend && CLK_EN);
  c_fast_irq: cover property (@(posedge CORE_CLK) full_speed ##[1:200] !full_speed);
  c_lock: cover property (@(posedge CORE_CLK) !lock ##1 lock);

endmodule : pcc_top

/* File: test/test_pcc_top.sv */
/*
  Self-checking bench for pcc_top: AHB-Lite register access, core clock enable rates,
  lock and strap reporting, oscillator sleep control and the fast-interrupt override.
  Assumes one 200 MHz clock, CLK_EN held high except during the last write, and a single slave whose HREADYOUT is HREADY.
*/
`timescale 1ns/100ps
`define CHK(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("unexpected %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module test_pcc_top
  import pcc_pkg::*;
;
  logic        core_clk;
  logic        rst_n;
  logic        clk_en;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        pll_tracking;
  logic        ext_access_pin;
  logic        power_down;
  logic        irq_entry;
  logic        irq_return;
  logic        core_clk_en;
  logic        osc_run;
  logic [15:0] pll_mult_factor;
  logic [31:0] rd;
  int          err_count;
  int          checks;
  int          cycles;

  pcc_top uut (
    .CORE_CLK(core_clk), .RST_N(rst_n), .CLK_EN(clk_en), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .PLL_TRACKING(pll_tracking),
    .EXT_ACCESS_PIN(ext_access_pin), .POWER_DOWN(power_down), .IRQ_ENTRY(irq_entry),
    .IRQ_RETURN(irq_return), .CORE_CLK_EN(core_clk_en), .OSC_RUN(osc_run),
    .PLL_MULT_FACTOR(pll_mult_factor)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task stop_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  // Longest test path is well under two thousand cycles; this ceiling only catches a hang
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      err_count++;
      stop_test();
    end
  end

  // No wait-state count is assumed; only the cycle ceiling ends a stuck wait
  task wait_rdy;
    do
      @(posedge core_clk);
    while (hreadyout !== 1'b1);
  endtask : wait_rdy

  // One single word transfer; read data is taken at the edge that ends the data phase
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask : do_reset

  // Two periods are skipped because a new rate is adopted only at a period boundary
  task rate(input int exp);
    int p;
    int k;
    for (k = 0; k < 3; k++)
    begin
      p = 0;
      do
      begin
        @(posedge core_clk);
        p++;
      end while (core_clk_en !== 1'b1);
    end
    `CHK("core clock period", exp, p)
  endtask : rate

  task pulse_irq(input logic ret);
    if (ret)
      irq_return <= 1'b1;
    else
      irq_entry <= 1'b1;
    @(posedge core_clk);
    irq_return <= 1'b0;
    irq_entry  <= 1'b0;
  endtask : pulse_irq

  task reg_is(input logic [7:0] exp);
    bus(1'b0, {20'h0, PCC_CTRL_OFFSET}, 32'h0);
    `CHK("control register", {24'h0, exp}, rd)
  endtask : reg_is

  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    pll_tracking = 1'b1;
    ext_access_pin = 1'b1;
    power_down = 1'b0;
    irq_entry = 1'b0;
    irq_return = 1'b0;
    do_reset();
    repeat (6) @(posedge core_clk);
    reg_is(PCC_CTRL_RESET | 8'h50);
    `CHK("multiplier", 16'h0180, pll_mult_factor)
    `CHK("response", 1'b0, hresp)
    rate(8);
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, 32'h0, c);
      rate(1 << c);
    end
    pll_tracking <= 1'b0;
    repeat (6) @(posedge core_clk);
    bus(1'b1, 32'h0, 32'hD7);
    reg_is(8'h97);
    ext_access_pin <= 1'b0;
    pll_tracking <= 1'b1;
    repeat (6) @(posedge core_clk);
    reg_is(8'hD7);
    bus(1'b1, 32'h0, 32'h0);
    reg_is(8'h50);
    bus(1'b1, 32'h4, 32'hFF);
    bus(1'b0, 32'h4, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    reg_is(8'h50);
    bus(1'b1, 32'h0, 32'h83);
    repeat (3) @(posedge core_clk);
    `CHK("oscillator awake", 1'b1, osc_run)
    power_down <= 1'b1;
    pll_tracking <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK("oscillator halted", 1'b0, osc_run)
    reg_is(8'h93);
    bus(1'b1, 32'h0, 32'h03);
    repeat (3) @(posedge core_clk);
    `CHK("oscillator kept", 1'b1, osc_run)
    power_down <= 1'b0;
    pll_tracking <= 1'b1;
    // Wake-up: software polls the lock flag before trusting the frequency
    do
      bus(1'b0, 32'h0, 32'h0);
    while (rd[PCC_LOCK_BIT] !== 1'b1);
    `CHK("lock after wake", 32'h00000053, rd)
    bus(1'b1, 32'h0, 32'h0D);
    rate(32);
    pulse_irq(1'b0);
    rate(1);
    pulse_irq(1'b1);
    rate(32);
    bus(1'b1, 32'h0, 32'h05);
    pulse_irq(1'b0);
    rate(32);
    pulse_irq(1'b1);
    do_reset();
    repeat (6) @(posedge core_clk);
    reg_is(8'h43);
    // Clock enable low: the transfer is not taken, so the divider code stays
    clk_en <= 1'b0;
    bus(1'b1, 32'h0, 32'h07);
    clk_en <= 1'b1;
    reg_is(8'h43);
    stop_test();
  end
endmodule : test_pcc_top
